// file: hdl/scc_core.sv
// scc_core: serial peripheral with width, fault and pin-direction control.
// assumes: register master on the core clock; pins asynchronous.
// Operation
// - width bit picks 8 or 16 bits
// - master width/fault/pin change aborts transfer
// - master bidir oe change aborts transfer in bidir pin mode
// - master fault enable selects select-pin use
// - slave uses select pin as input only
// - bidir oe gates active output buffer
// - stop-in-wait halts serial clock in wait
// - master normal: in on MISO, out MOSI
// - master bidir: MOSI in or shared
// - slave normal: out MISO, in MOSI
// - slave bidir: MISO in or shared
`timescale 1ns/1ps
`default_nettype none
module scc_core (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic O_IRQ,
  input wire logic I_WAIT,
  input wire logic I_SCK,
  output logic O_SCK,
  output logic O_SCK_OE,
  input wire logic I_MOSI,
  output logic O_MOSI,
  output logic O_MOSI_OE,
  input wire logic I_MISO,
  output logic O_MISO,
  output logic O_MISO_OE,
  input wire logic I_SS_N
);
  // =====================================================
  // functions
  function automatic logic [4:0] nbits(input logic wide);
    nbits = wide ? scc_pkg::BITS_WIDE : scc_pkg::BITS_NARROW;
  endfunction
  function automatic logic top_bit(input logic [15:0] v, input logic wide);
    top_bit = wide ? v[15] : v[7];
  endfunction

  // =====================================================
  // pin synchronisers
  logic [3:0] pin_s;
  logic sck_s, mosi_s, miso_s, ss_n_s;

  scc_sync #(.W(4), .RST_VAL(4'h8)) u_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_async({I_SS_N, I_MISO, I_MOSI, I_SCK}),
    .o_sync(pin_s)
  );
  assign {ss_n_s, miso_s, mosi_s, sck_s} = pin_s; // split back into pins

  // =====================================================
  // registers
  logic [7:0] ctrl1_q, ctrl1_d;
  logic [7:0] ctrl2_q, ctrl2_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] dhi_q, dhi_d;
  logic [7:0] dlo_q, dlo_d;
  logic [7:0] div_q, div_d;
  logic [7:0] rdata_q, rdata_d;
  logic [15:0] rx_q, rx_d;
  logic enable, master, wide, fault_en, bidir_oe, stop_wait, pin_bidir;
  logic wr_ctrl2, abort, fault_set, done_set, start;

  assign enable = ctrl1_q[scc_pkg::C1_ENABLE];
  assign master = ctrl1_q[scc_pkg::C1_MASTER];
  assign wide = ctrl2_q[scc_pkg::C2_WIDTH];
  assign fault_en = ctrl2_q[scc_pkg::C2_FAULT_EN];
  assign bidir_oe = ctrl2_q[scc_pkg::C2_BIDIR_OE];
  assign stop_wait = ctrl2_q[scc_pkg::C2_STOP_WAIT];
  assign pin_bidir = ctrl2_q[scc_pkg::C2_PIN_BIDIR];
  assign wr_ctrl2 = I_WR && (I_ADDR == scc_pkg::ADR_CTRL2);

  // master: a changed width, fault enable or pin mode aborts
  always_comb begin
    abort = 1'b0;
    if (wr_ctrl2 && master) begin
      if (I_WDATA[scc_pkg::C2_WIDTH] != wide) abort = 1'b1;
      if (I_WDATA[scc_pkg::C2_FAULT_EN] != fault_en) abort = 1'b1;
      if (I_WDATA[scc_pkg::C2_PIN_BIDIR] != pin_bidir) abort = 1'b1;
      if (pin_bidir && I_WDATA[scc_pkg::C2_BIDIR_OE] != bidir_oe) abort = 1'b1;
    end
  end

  // mode fault: select pin driven low by another master
  assign fault_set = enable && master && fault_en && !ss_n_s;
  // register file next values; hardware sets win over clears
  always_comb begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    mask_d = mask_q;
    dhi_d = dhi_q;
    dlo_d = dlo_q;
    div_d = div_q;
    stat_d = stat_q;
    rdata_d = 8'h00;
    if (I_WR) begin
      unique case (I_ADDR)
        scc_pkg::ADR_CTRL1: ctrl1_d = I_WDATA & 8'h03;
        scc_pkg::ADR_CTRL2: ctrl2_d = I_WDATA & scc_pkg::C2_USED_MASK;
        scc_pkg::ADR_STAT: stat_d = stat_q & ~I_WDATA;
        scc_pkg::ADR_MASK: mask_d = I_WDATA & scc_pkg::ST_USED_MASK;
        scc_pkg::ADR_DHI: if (wide) dhi_d = I_WDATA;
        scc_pkg::ADR_DLO: dlo_d = I_WDATA;
        scc_pkg::ADR_DIV: div_d = I_WDATA;
        default: ;
      endcase
    end
    if (fault_set) begin
      stat_d[scc_pkg::ST_FAULT] = 1'b1;
      ctrl1_d[scc_pkg::C1_MASTER] = 1'b0;
    end
    if (done_set) stat_d[scc_pkg::ST_DONE] = 1'b1;
    if (I_RD) begin
      unique case (I_ADDR)
        scc_pkg::ADR_CTRL1: rdata_d = ctrl1_q;
        scc_pkg::ADR_CTRL2: rdata_d = ctrl2_q;
        scc_pkg::ADR_STAT: rdata_d = stat_q;
        scc_pkg::ADR_MASK: rdata_d = mask_q;
        scc_pkg::ADR_DHI: rdata_d = wide ? rx_q[15:8] : 8'h00;
        scc_pkg::ADR_DLO: rdata_d = rx_q[7:0];
        scc_pkg::ADR_DIV: rdata_d = div_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // register file storage
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      ctrl1_q <= scc_pkg::RST_CTRL1;
      ctrl2_q <= scc_pkg::RST_CTRL2;
      stat_q <= scc_pkg::RST_STAT;
      mask_q <= scc_pkg::RST_MASK;
      dhi_q <= scc_pkg::RST_DATA;
      dlo_q <= scc_pkg::RST_DATA;
      div_q <= scc_pkg::RST_DIV;
      rdata_q <= 8'h00;
    end else begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      dhi_q <= dhi_d;
      dlo_q <= dlo_d;
      div_q <= div_d;
      rdata_q <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_IRQ = |(stat_q & mask_q);

  // =====================================================
  // serial clock divider, halted in wait when asked
  logic tick, run_clk;
  scc_pkg::scc_state_t state_q, state_d;

  assign run_clk = (state_q == scc_pkg::SCC_RUN) && master && !(stop_wait && I_WAIT);

  scc_clkdiv u_div (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_run(run_clk),
    .i_clear(state_q == scc_pkg::SCC_IDLE),
    .i_div(div_q),
    .o_tick(tick)
  );

  // =====================================================
  // shift engine
  logic [15:0] sh_q, sh_d;
  logic [4:0] cnt_q, cnt_d;
  logic sck_q, sck_d, rxb_q, rxb_d, sck_old_q, sck_old_d;
  logic rx_pin, sck_rise, sck_fall, ss_act;

  // receive pin follows the pin mode table
  always_comb begin
    if (master) begin
      rx_pin = pin_bidir ? mosi_s : miso_s;
    end else begin
      rx_pin = pin_bidir ? miso_s : mosi_s;
    end
  end

  // slave select is only an input in slave mode
  assign ss_act = enable && !master && !ss_n_s;
  assign sck_rise = sck_s && !sck_old_q;
  assign sck_fall = !sck_s && sck_old_q;
  assign start = I_WR && (I_ADDR == scc_pkg::ADR_DLO) && enable && master;

  // engine next values
  always_comb begin
    state_d = state_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    sck_d = sck_q;
    rxb_d = rxb_q;
    rx_d = rx_q;
    done_set = 1'b0;
    sck_old_d = sck_s;
    unique case (state_q)
      scc_pkg::SCC_IDLE: begin
        sck_d = 1'b0;
        cnt_d = 5'h00;
        if (start && state_q == scc_pkg::SCC_IDLE) begin
          sh_d = {wide ? dhi_q : 8'h00, I_WDATA};
          state_d = scc_pkg::SCC_RUN;
        end else if (ss_act) begin
          sh_d = {wide ? dhi_q : 8'h00, dlo_q};
          state_d = scc_pkg::SCC_RUN;
        end
      end
      scc_pkg::SCC_RUN: begin
        if (master) begin
          if (tick) begin
            sck_d = !sck_q;
            if (!sck_q) begin
              rxb_d = rx_pin;
            end else begin
              sh_d = {sh_q[14:0], rxb_q};
              cnt_d = cnt_q + 5'h01;
              if (cnt_q == nbits(wide) - 5'h01) begin
                rx_d = {sh_q[14:0], rxb_q};
                done_set = 1'b1;
                state_d = scc_pkg::SCC_IDLE;
              end
            end
          end
        end else if (!ss_act) begin
          state_d = scc_pkg::SCC_IDLE;
        end else if (sck_rise) begin
          rxb_d = rx_pin;
        end else if (sck_fall) begin
          sh_d = {sh_q[14:0], rxb_q};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == nbits(wide) - 5'h01) begin
            rx_d = {sh_q[14:0], rxb_q};
            done_set = 1'b1;
            cnt_d = 5'h00;
            sh_d = {wide ? dhi_q : 8'h00, dlo_q};
          end
        end
      end
    endcase
    if (abort || fault_set || !enable) begin
      state_d = scc_pkg::SCC_IDLE;
      sck_d = 1'b0;
    end
  end

  // engine storage
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      state_q <= scc_pkg::SCC_IDLE;
      sh_q <= 16'h0000;
      cnt_q <= 5'h00;
      sck_q <= 1'b0;
      rxb_q <= 1'b0;
      rx_q <= 16'h0000;
      sck_old_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      sck_q <= sck_d;
      rxb_q <= rxb_d;
      rx_q <= rx_d;
      sck_old_q <= sck_old_d;
    end
  end

  // =====================================================
  // pin drivers and output enables
  always_comb begin
    O_SCK_OE = enable && master;
    O_MOSI_OE = 1'b0;
    O_MISO_OE = 1'b0;
    if (enable && master) begin
      O_MOSI_OE = pin_bidir ? bidir_oe : 1'b1;
    end else if (ss_act) begin
      O_MISO_OE = pin_bidir ? bidir_oe : 1'b1;
    end
  end

  assign O_SCK = sck_q;
  assign O_MOSI = top_bit(sh_q, wide);
  assign O_MISO = top_bit(sh_q, wide);

  // =====================================================
  // assertions
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);
  a_abort_width_chg: assert property (
    (wr_ctrl2 && master && I_WDATA[scc_pkg::C2_WIDTH] != wide)
      |=> state_q == scc_pkg::SCC_IDLE && !O_SCK)
    else $error("width change did not abort");
  a_abort_bidir_oe: assert property (
    (wr_ctrl2 && master && pin_bidir && I_WDATA[scc_pkg::C2_BIDIR_OE] != bidir_oe)
      |=> state_q == scc_pkg::SCC_IDLE)
    else $error("output enable change did not abort");
  a_fault_off_quiet: assert property (
    (master && !fault_en && !stat_q[scc_pkg::ST_FAULT] && !(I_WR && I_ADDR == scc_pkg::ADR_CTRL2))
      |=> !stat_q[scc_pkg::ST_FAULT])
    else $error("fault set while fault enable clear");
  a_slave_ss_input: assert property (
    (!master && !stat_q[scc_pkg::ST_FAULT]) |=> !stat_q[scc_pkg::ST_FAULT])
    else $error("slave select raised fault in slave mode");
  a_bidir_gate_oe: assert property (
    (enable && pin_bidir && master) |-> (O_MOSI_OE == bidir_oe) && !O_MISO_OE)
    else $error("bidir output buffer not gated");
  a_wait_sck_hold: assert property (
    (stop_wait && I_WAIT && $past(stop_wait && I_WAIT && enable && !abort && !fault_set))
      |-> $stable(O_SCK))
    else $error("serial clock moved in wait");
  a_master_norm_pins: assert property (
    (enable && master && !pin_bidir) |-> O_MOSI_OE && !O_MISO_OE)
    else $error("master normal pin use wrong");
  a_slave_bidir_pins: assert property (
    (!master && pin_bidir) |-> !O_MOSI_OE)
    else $error("slave bidir drove other pin");
  a_fault_release_out: assert property (
    fault_set |=> stat_q[scc_pkg::ST_FAULT] && !O_SCK_OE && !O_MOSI_OE)
    else $error("mode fault did not release outputs");
  a_narrow_high_zero: assert property (
    (I_RD && I_ADDR == scc_pkg::ADR_DHI && !wide) |=> O_RDATA == 8'h00)
    else $error("high byte read nonzero in narrow mode");
endmodule // scc_core
`default_nettype wire

// file: hdl/scc_pkg.sv
// scc_pkg: register map, field positions and reset values of the
// serial control block.
// assumes: an 8-bit plain register port with a 3-bit address.
package scc_pkg;
  // =====================================================
  // register offsets
  localparam logic [2:0] ADR_CTRL1 = 3'h0;
  localparam logic [2:0] ADR_CTRL2 = 3'h1;
  localparam logic [2:0] ADR_STAT = 3'h2;
  localparam logic [2:0] ADR_MASK = 3'h3;
  localparam logic [2:0] ADR_DHI = 3'h4;
  localparam logic [2:0] ADR_DLO = 3'h5;
  localparam logic [2:0] ADR_DIV = 3'h6;
  // =====================================================
  // control one fields
  localparam int C1_ENABLE = 0;
  localparam int C1_MASTER = 1;
  // =====================================================
  // serial_control_two fields
  localparam int C2_WIDTH = 6;
  localparam int C2_FAULT_EN = 4;
  localparam int C2_BIDIR_OE = 3;
  localparam int C2_STOP_WAIT = 1;
  localparam int C2_PIN_BIDIR = 0;
  localparam logic [7:0] C2_USED_MASK = 8'h5B;
  // =====================================================
  // status and mask fields
  localparam int ST_DONE = 0;
  localparam int ST_FAULT = 1;
  localparam logic [7:0] ST_USED_MASK = 8'h03;
  // =====================================================
  // reset values
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h03;
  // =====================================================
  // transfer widths in bits
  localparam logic [4:0] BITS_NARROW = 5'h08;
  localparam logic [4:0] BITS_WIDE = 5'h10;
  // =====================================================
  // engine states
  typedef enum logic [0:0] {
    SCC_IDLE,
    SCC_RUN
  } scc_state_t;
endpackage

// file: hdl/scc_sync.sv
// scc_sync: two-flop synchroniser for pins from outside the core clock.
// assumes: inputs are asynchronous levels; reset value is a parameter.
`timescale 1ns/1ps
`default_nettype none
module scc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // =====================================================
  // next values: first stage is read only by the second
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // register both stages
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule // scc_sync
`default_nettype wire

// file: hdl/scc_clkdiv.sv
// scc_clkdiv: half-period tick generator for the serial clock.
// assumes: i_div is stable while i_run is high; i_clear restarts.
`timescale 1ns/1ps
`default_nettype none
module scc_clkdiv (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic [7:0] i_div,
  output logic o_tick
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic tick_d;

  // =====================================================
  // count div+1 cycles per tick, hold when not running
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (i_clear) begin
      cnt_d = 8'h00;
    end else if (i_run) begin
      if (cnt_q >= i_div) begin
        cnt_d = 8'h00;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  // register counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_tick = tick_d;
endmodule // scc_clkdiv
`default_nettype wire

// file: verification/scc_far_slave.sv
// scc_far_slave: remote serial slave that sits on the master-side pins.
// assumes: mode 0, msb first; tx word is loaded by a pulse between frames.
`timescale 1ns/1ps
`default_nettype none
module scc_far_slave (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_load,
  input wire logic [15:0] i_tx,
  output logic o_miso,
  output logic [15:0] o_rx
);
  logic [15:0] tx_q;
  // =====================================================
  // shift out after each falling edge; inverted fill keeps the line moving
  always @(negedge i_sck or posedge i_load) begin
    if (i_load) begin
      tx_q <= i_tx;
    end else begin
      tx_q <= {tx_q[14:0], ~tx_q[15]};
    end
  end
  // sample the master's data on each rising edge
  always @(posedge i_sck) begin
    o_rx <= {o_rx[14:0], i_mosi};
  end
  assign o_miso = tx_q[15]; // msb first
endmodule // scc_far_slave
`default_nettype wire

// file: verification/spi_control_and_pin_config_bench.sv
// spi_control_and_pin_config_bench: register-level tests of the serial block.
// assumes: scc_pkg and design compiled first; 200 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module spi_control_and_pin_config_bench;
  logic clk, rst_n, wr, rd, wait_m, b_sck, b_mosi, ss_n, f_load, sck_ok;
  logic irq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, f_miso, sck_w, mosi_w, miso_w;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] f_tx, f_rx, got;
  logic [7:0] ab_from [4] = '{8'h00, 8'h00, 8'h00, 8'h09};
  logic [7:0] ab_to [4] = '{8'h40, 8'h10, 8'h01, 8'h01};
  int errors, check_count;
  // =====================================================
  // pin resolution: whoever enables drives the wire
  assign sck_w = sck_oe ? sck : b_sck;
  assign mosi_w = mosi_oe ? mosi : b_mosi;
  assign miso_w = miso_oe ? miso : f_miso;
  scc_core uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .I_WAIT(wait_m), .I_SCK(sck_w),
    .O_SCK(sck), .O_SCK_OE(sck_oe), .I_MOSI(mosi_w), .O_MOSI(mosi), .O_MOSI_OE(mosi_oe),
    .I_MISO(miso_w), .O_MISO(miso), .O_MISO_OE(miso_oe), .I_SS_N(ss_n));
  scc_far_slave far (.i_sck(sck_w), .i_mosi(mosi_w), .i_load(f_load), .i_tx(f_tx),
    .o_miso(f_miso), .o_rx(f_rx));
  // =====================================================
  // checking and bus tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd8(input logic [2:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", {8'h00, rdata}, {8'h00, exp});
    @(posedge clk);
  endtask
  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < n) begin
      @(posedge clk);
      k++;
    end
    chk("interrupt", {15'h0, irq}, 16'h0001);
  endtask
  // one master word against the far slave
  task automatic mxfer(input logic [15:0] tx, input logic [15:0] ftx, input logic wide);
    f_tx <= ftx;
    f_load <= 1'b1;
    @(posedge clk);
    f_load <= 1'b0;
    if (wide) wr8(scc_pkg::ADR_DHI, tx[15:8]);
    wr8(scc_pkg::ADR_DLO, tx[7:0]);
    wait_irq(300);
    chk("far rx", wide ? f_rx : {8'h00, f_rx[7:0]}, wide ? tx : {8'h00, tx[7:0]});
    rd8(scc_pkg::ADR_DLO, wide ? ftx[7:0] : ftx[15:8]);
    if (wide) rd8(scc_pkg::ADR_DHI, ftx[15:8]);
    wr8(scc_pkg::ADR_STAT, 8'h03);
    chk("irq cleared", {15'h0, irq}, 16'h0000);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // =====================================================
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run;
  end
  // =====================================================
  // test sequence
  initial begin
    {rst_n, wr, rd, wait_m, b_sck, b_mosi, f_load} = 7'h00;
    ss_n = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    f_tx = 16'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd8(scc_pkg::ADR_CTRL2, scc_pkg::RST_CTRL2);
    rd8(scc_pkg::ADR_DIV, scc_pkg::RST_DIV);
    rd8(3'h7, 8'h00);
    chk("enables", {13'h0, sck_oe, mosi_oe, miso_oe}, 16'h0000);
    wr8(scc_pkg::ADR_CTRL2, 8'hFF);
    rd8(scc_pkg::ADR_CTRL2, scc_pkg::C2_USED_MASK);
    wr8(scc_pkg::ADR_CTRL2, 8'h00);
    $display("test reset done");
    wr8(scc_pkg::ADR_MASK, 8'h03);
    wr8(scc_pkg::ADR_CTRL1, 8'h03);
    mxfer(16'h00A5, 16'h3C00, 1'b0);
    rd8(scc_pkg::ADR_DHI, 8'h00);
    wr8(scc_pkg::ADR_CTRL2, 8'h40);
    mxfer(16'h1234, 16'h9617, 1'b1);
    $display("test width done");
    for (int i = 0; i < 4; i++) begin
      wr8(scc_pkg::ADR_CTRL2, ab_from[i]);
      wr8(scc_pkg::ADR_DLO, 8'h81);
      repeat (20) @(posedge clk);
      wr8(scc_pkg::ADR_CTRL2, ab_to[i]);
      repeat (300) @(posedge clk);
      rd8(scc_pkg::ADR_STAT, 8'h00);
      chk("sck idle", {15'h0, sck}, 16'h0000);
    end
    $display("test abort done");
    wr8(scc_pkg::ADR_CTRL2, 8'h02);
    wait_m <= 1'b1;
    wr8(scc_pkg::ADR_DLO, 8'h55);
    sck_ok = 1'b1;
    repeat (100) begin
      @(posedge clk);
      if (sck !== 1'b0) sck_ok = 1'b0;
    end
    chk("sck held", {15'h0, sck_ok}, 16'h0001);
    wait_m <= 1'b0;
    wait_irq(200);
    wr8(scc_pkg::ADR_STAT, 8'h03);
    wr8(scc_pkg::ADR_CTRL2, 8'h00);
    wait_m <= 1'b1;
    wr8(scc_pkg::ADR_DLO, 8'h55);
    wait_irq(200);
    wait_m <= 1'b0;
    wr8(scc_pkg::ADR_STAT, 8'h03);
    $display("test wait done");
    ss_n <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr8(scc_pkg::ADR_CTRL1, {6'h00, i[2], 1'b1});
      wr8(scc_pkg::ADR_CTRL2, {4'h0, i[0], 2'b00, i[1]});
      repeat (4) @(posedge clk);
      chk("mosi oe", {15'h0, mosi_oe}, {15'h0, i[2] & (~i[1] | i[0])});
      chk("miso oe", {15'h0, miso_oe}, {15'h0, ~i[2] & (~i[1] | i[0])});
    end
    rd8(scc_pkg::ADR_STAT, 8'h00);
    ss_n <= 1'b1;
    $display("test pins done");
    wr8(scc_pkg::ADR_CTRL1, 8'h03);
    wr8(scc_pkg::ADR_CTRL2, 8'h10);
    ss_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("fault irq", {15'h0, irq}, 16'h0001);
    chk("released", {13'h0, sck_oe, mosi_oe, miso_oe}, 16'h0001);
    rd8(scc_pkg::ADR_STAT, 8'h02);
    rd8(scc_pkg::ADR_CTRL1, 8'h01);
    ss_n <= 1'b1;
    wr8(scc_pkg::ADR_STAT, 8'h03);
    $display("test fault done");
    wr8(scc_pkg::ADR_DLO, 8'hC3);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1.3;
    for (int b = 7; b >= 0; b--) begin
      b_mosi <= b[0] ^ b[1] ^ b[2] ? 1'b1 : 1'b0;
      #24 b_sck <= 1'b1;
      got[b] = miso_w;
      #24 b_sck <= 1'b0;
    end
    @(posedge clk);
    wait_irq(40);
    ss_n <= 1'b1;
    chk("slave out", {8'h00, got[7:0]}, 16'h00C3);
    rd8(scc_pkg::ADR_STAT, 8'h01);
    rd8(scc_pkg::ADR_DLO, 8'h96);
    wr8(scc_pkg::ADR_MASK, 8'h00);
    chk("masked", {15'h0, irq}, 16'h0000);
    wr8(scc_pkg::ADR_MASK, 8'h03);
    chk("unmasked", {15'h0, irq}, 16'h0001);
    wr8(scc_pkg::ADR_STAT, 8'h03);
    chk("cleared", {15'h0, irq}, 16'h0000);
    $display("test slave done");
    wr8(scc_pkg::ADR_CTRL1, 8'h03);
    wr8(scc_pkg::ADR_CTRL2, 8'h01);
    b_mosi <= 1'b1;
    wr8(scc_pkg::ADR_DLO, 8'h00);
    chk("bidir mosi oe", {15'h0, mosi_oe}, 16'h0000);
    wait_irq(200);
    rd8(scc_pkg::ADR_DLO, 8'hFF);
    $display("test bidir done");
    complete_run;
  end
endmodule // spi_control_and_pin_config_bench
`default_nettype wire
